// >>> rtl/gpc_consts.svh
/*
 Holds the constants of the pin interrupt and pad configuration block:
 register byte offsets, access op field, reset values and filter depth.
 Assumes a 9-bit APB byte address and 32-bit data.
*/
`ifndef GPC_CONSTS_SVH
`define GPC_CONSTS_SVH

// byte offsets, each config register group spans four words; flag, impl and version are single words
`define GPC_OFF_IRQ_EN 9'h090
`define GPC_OFF_TRIG_LOW 9'h0a0
`define GPC_OFF_TRIG_HIGH 9'h0b0
`define GPC_OFF_GLITCH 9'h0c0
`define GPC_OFF_FLAG_RD 9'h0d0
`define GPC_OFF_FLAG_CLR 9'h0d8
`define GPC_OFF_DRIVE_LOW 9'h100
`define GPC_OFF_DRIVE_HIGH 9'h110
`define GPC_OFF_SLEW 9'h130
`define GPC_OFF_SCHMITT 9'h160
`define GPC_OFF_EVENT 9'h180
`define GPC_OFF_IMPL 9'h1f8
`define GPC_OFF_VERSION 9'h1fc

// access op field inside the byte address
`define GPC_OP_MSB 3
`define GPC_OP_LSB 2

// version word field positions
`define GPC_VER_MSB 11
`define GPC_VER_LSB 0
`define GPC_VAR_MSB 19
`define GPC_VAR_LSB 16

// reset values
`define GPC_RST_WORD 32'h00000000
`define GPC_RST_ALL 32'hffffffff

// glitch filter: samples that must agree before the level moves
`define GPC_GF_DEPTH 3

`endif

// >>> rtl/gpc_pkg.sv
/*
 Types shared by the pin interrupt and pad configuration block.
 Assumes the constants header is included where offsets are needed.
*/
package gpc_pkg;
   // access kind selected by address bits 3:2
   typedef enum logic [1:0] {
      GPC_OP_WRITE = 2'h0,
      GPC_OP_SET = 2'h1,
      GPC_OP_CLEAR = 2'h2,
      GPC_OP_TOGGLE = 2'h3
   } gpc_op_t;
   // trigger encoding, {high bit, low bit}
   typedef enum logic [1:0] {
      GPC_TRIG_CHANGE = 2'h0,
      GPC_TRIG_RISE = 2'h1,
      GPC_TRIG_FALL = 2'h2,
      GPC_TRIG_RSVD = 2'h3
   } gpc_trig_t;
endpackage

// >>> rtl/gpc_top.sv
/*
 Holds one 32-pin port: pin input synchronisers, optional glitch filter,
 edge and change detection, sticky flags with interrupt, event forwarding
 to the event network, pad configuration outputs and an APB slave.
 Assumes pins are asynchronous to pclk and the pads take the config
 bits as static levels.
*/
// Our own choice: the APB slave port.
// Notes on behaviour
// R01: two mode bits choose change, rise, fall
// R02: glitch filter ahead of detection when enabled
// R03: software changes filter only while irq disabled
// R04: filter change may raise spurious flag
// R05: detected condition sets pin flag
// R06: flag meaningful only while irq enabled
// R07: two bits set drive strength
// R08: slew bit enables slew rate control
// R09: schmitt bit enables input schmitt trigger
// R10: event forwarded only when event enabled
// R11: read-only implemented pins word
// R12: read-only version and variant word
// R13: four offsets: write, set, clear, toggle
// R14: interrupt generated only when irq enabled
// R15: writing one at clear address clears flag
// R16: pins synchronised, consecutive samples compared
// R17: irq high while enabled flag set
`timescale 1ns/100ps
`include "gpc_consts.svh"

module gpc_top #(
   // which pins exist; arbitrary default
   parameter logic [31:0] IMPL_PINS = 32'hffffffff,
   // module version; value is arbitrary
   parameter logic [11:0] MOD_VERSION = 12'h001,
   // variant number; value is arbitrary
   parameter logic [3:0] MOD_VARIANT = 4'h0
) (
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [8:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // pins, asynchronous
   input wire logic [31:0] pin_in,
   // pad controls
   output logic [31:0] drive_strength_bit_low,
   output logic [31:0] drive_strength_bit_high,
   output logic [31:0] slew_control_on,
   output logic [31:0] schmitt_on,
   // one-cycle event pulses per pin
   output logic [31:0] pin_event,
   // level interrupt
   output logic irq
);

   // configuration registers
   logic [31:0] pin_irq_enable_q; // interrupt enable
   logic [31:0] irq_trigger_sel_low_q; // mode bit 0
   logic [31:0] irq_trigger_sel_high_q; // mode bit 1
   logic [31:0] glitch_filter_on_q; // filter enable
   logic [31:0] drive_low_q; // drive bit 0
   logic [31:0] drive_high_q; // drive bit 1
   logic [31:0] slew_q; // slew control
   logic [31:0] schmitt_q; // schmitt enable
   logic [31:0] event_forward_on_q; // event enable
   logic [31:0] pin_irq_flag_q; // sticky flags

   // apb answer flops, then the irq and event output flops
   logic pready_q;
   logic pslverr_q;
   logic [31:0] prdata_q;
   logic irq_q;
   logic [31:0] pin_event_q;

   // input path
   logic [31:0] sync1_q; // first stage, read by sync2_q only
   logic [31:0] sync2_q; // synchronised level
   logic [31:0] cond; // selected condition this cycle

   // bus decode
   logic setup_ph; // first cycle of a transfer
   logic wr_done; // write takes effect now
   logic [4:0] grp; // four-word group index
   gpc_pkg::gpc_op_t op; // access kind
   logic [31:0] rd_word; // read mux
   logic rd_hit; // address mapped

   // write strobes per config group
   logic we_ien;
   logic we_tsl;
   logic we_tsh;
   logic we_gfe;
   logic we_dsl;
   logic we_dsh;
   logic we_slw;
   logic we_sch;
   logic we_evt;
   logic flag_clr; // flag clear write
   logic [31:0] clr_mask; // bits to clear

   // group index of an offset
   function automatic logic [4:0] grp_of(input logic [8:0] off);
      grp_of = off[8:4];
   endfunction

   // new value for write, set, clear or toggle
   function automatic logic [31:0] apply(
      input logic [31:0] old,
      input logic [31:0] wd,
      input gpc_pkg::gpc_op_t k
   );
      logic [31:0] r;
      r = old;
      case (k)
         gpc_pkg::GPC_OP_WRITE: r = wd;
         gpc_pkg::GPC_OP_SET: r = old | wd;
         gpc_pkg::GPC_OP_CLEAR: r = old & ~wd;
         gpc_pkg::GPC_OP_TOGGLE: r = old ^ wd;
         default: r = old;
      endcase
      // absent pins keep zero
      apply = r & IMPL_PINS;
   endfunction

   // address pieces
   assign grp = paddr[8:4];
   assign op = gpc_pkg::gpc_op_t'(paddr[`GPC_OP_MSB:`GPC_OP_LSB]);
   assign setup_ph = psel & ~penable;
   // pready_q is high only in the access cycle
   assign wr_done = psel & penable & pready_q & pwrite;

   // config strobes, each group decodes four words [R13]
   assign we_ien = wr_done & (grp == grp_of(`GPC_OFF_IRQ_EN));
   assign we_tsl = wr_done & (grp == grp_of(`GPC_OFF_TRIG_LOW));
   assign we_tsh = wr_done & (grp == grp_of(`GPC_OFF_TRIG_HIGH));
   assign we_gfe = wr_done & (grp == grp_of(`GPC_OFF_GLITCH));
   assign we_dsl = wr_done & (grp == grp_of(`GPC_OFF_DRIVE_LOW));
   assign we_dsh = wr_done & (grp == grp_of(`GPC_OFF_DRIVE_HIGH));
   assign we_slw = wr_done & (grp == grp_of(`GPC_OFF_SLEW));
   assign we_sch = wr_done & (grp == grp_of(`GPC_OFF_SCHMITT));
   assign we_evt = wr_done & (grp == grp_of(`GPC_OFF_EVENT));

   // write one clears, write zero leaves [R15]
   assign flag_clr = wr_done & (paddr == `GPC_OFF_FLAG_CLR);
   assign clr_mask = flag_clr ? pwdata : `GPC_RST_WORD;

   // read mux, any of the four words reads a config register; flags, impl and version each read at one word only
   always_comb begin
      rd_word = `GPC_RST_WORD;
      rd_hit = 1'b1;
      if (grp == grp_of(`GPC_OFF_IRQ_EN)) begin
         rd_word = pin_irq_enable_q;
      end else if (grp == grp_of(`GPC_OFF_TRIG_LOW)) begin
         rd_word = irq_trigger_sel_low_q;
      end else if (grp == grp_of(`GPC_OFF_TRIG_HIGH)) begin
         rd_word = irq_trigger_sel_high_q;
      end else if (grp == grp_of(`GPC_OFF_GLITCH)) begin
         rd_word = glitch_filter_on_q;
      end else if (paddr == `GPC_OFF_FLAG_RD) begin
         rd_word = pin_irq_flag_q;
      end else if (paddr == `GPC_OFF_FLAG_CLR) begin
         // clear word is write only
         rd_word = `GPC_RST_WORD;
      end else if (grp == grp_of(`GPC_OFF_DRIVE_LOW)) begin
         rd_word = drive_low_q;
      end else if (grp == grp_of(`GPC_OFF_DRIVE_HIGH)) begin
         rd_word = drive_high_q;
      end else if (grp == grp_of(`GPC_OFF_SLEW)) begin
         rd_word = slew_q;
      end else if (grp == grp_of(`GPC_OFF_SCHMITT)) begin
         rd_word = schmitt_q;
      end else if (grp == grp_of(`GPC_OFF_EVENT)) begin
         rd_word = event_forward_on_q;
      end else if (paddr == `GPC_OFF_IMPL) begin
         // one bit per implemented pin [R11]
         rd_word = IMPL_PINS;
      end else if (paddr == `GPC_OFF_VERSION) begin
         // version and variant, other bits zero [R12]
         rd_word[`GPC_VER_MSB:`GPC_VER_LSB] = MOD_VERSION;
         rd_word[`GPC_VAR_MSB:`GPC_VAR_LSB] = MOD_VARIANT;
      end else begin
         // unmapped
         rd_hit = 1'b0;
      end
   end

   // apb answer: one wait-free access cycle after setup
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= `GPC_RST_WORD;
      end else if (setup_ph) begin
         // sample answer in setup, shown in access
         pready_q <= 1'b1;
         pslverr_q <= ~rd_hit;
         prdata_q <= pwrite ? `GPC_RST_WORD : rd_word;
      end else begin
         // drop after the completing edge
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= `GPC_RST_WORD;
      end
   end

   // interrupt enable
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_irq_enable_q <= `GPC_RST_WORD;
      end else if (we_ien) begin
         pin_irq_enable_q <= apply(pin_irq_enable_q, pwdata, op);
      end
   end

   // trigger mode bits [R01]
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_trigger_sel_low_q <= `GPC_RST_WORD;
         irq_trigger_sel_high_q <= `GPC_RST_WORD;
      end else begin
         if (we_tsl) begin
            irq_trigger_sel_low_q <= apply(irq_trigger_sel_low_q, pwdata, op);
         end
         if (we_tsh) begin
            irq_trigger_sel_high_q <= apply(irq_trigger_sel_high_q, pwdata, op);
         end
      end
   end

   // glitch filter enable; software keeps irq off while changing it [R03]
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         glitch_filter_on_q <= `GPC_RST_WORD;
      end else if (we_gfe) begin
         glitch_filter_on_q <= apply(glitch_filter_on_q, pwdata, op);
      end
   end

   // drive strength bits [R07]
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         drive_low_q <= `GPC_RST_WORD;
         drive_high_q <= `GPC_RST_WORD;
      end else begin
         if (we_dsl) begin
            drive_low_q <= apply(drive_low_q, pwdata, op);
         end
         if (we_dsh) begin
            drive_high_q <= apply(drive_high_q, pwdata, op);
         end
      end
   end

   // slew rate control [R08]
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         slew_q <= `GPC_RST_WORD;
      end else if (we_slw) begin
         slew_q <= apply(slew_q, pwdata, op);
      end
   end

   // schmitt trigger [R09]
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         schmitt_q <= `GPC_RST_WORD;
      end else if (we_sch) begin
         schmitt_q <= apply(schmitt_q, pwdata, op);
      end
   end

   // event enable
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         event_forward_on_q <= `GPC_RST_WORD;
      end else if (we_evt) begin
         event_forward_on_q <= apply(event_forward_on_q, pwdata, op);
      end
   end

   // two-stage synchroniser on every pin [R16]
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_q <= `GPC_RST_WORD;
         sync2_q <= `GPC_RST_WORD;
      end else begin
         sync1_q <= pin_in;
         sync2_q <= sync1_q;
      end
   end

   // per-pin filter and detector
   genvar gi;
   generate
      for (gi = 0; gi < 32; gi = gi + 1) begin : g_pin
         logic [`GPC_GF_DEPTH-1:0] hist_q; // recent synced samples
         logic filt_q; // filtered level
         logic prev_q; // last detection level
         logic lvl; // detection level now
         logic rise;
         logic fall;

         // filter: level moves only when all samples agree
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               hist_q <= '0;
               filt_q <= 1'b0;
            end else begin
               hist_q <= {hist_q[`GPC_GF_DEPTH-2:0], sync2_q[gi]};
               if (&hist_q) begin
                  filt_q <= 1'b1;
               end else if (~|hist_q) begin
                  filt_q <= 1'b0;
               end
            end
         end

         // bypass when filter is off [R02]
         // switching the source can look like an edge [R04]
         assign lvl = glitch_filter_on_q[gi] ? filt_q : sync2_q[gi];

         // previous sample for comparison [R16]
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               prev_q <= 1'b0;
            end else begin
               prev_q <= lvl;
            end
         end

         assign rise = lvl & ~prev_q;
         assign fall = ~lvl & prev_q;

         // trigger selection, reserved code never fires [R01]
         always_comb begin
            case (gpc_pkg::gpc_trig_t'({irq_trigger_sel_high_q[gi],
                                        irq_trigger_sel_low_q[gi]}))
               gpc_pkg::GPC_TRIG_CHANGE: cond[gi] = rise | fall;
               gpc_pkg::GPC_TRIG_RISE: cond[gi] = rise;
               gpc_pkg::GPC_TRIG_FALL: cond[gi] = fall;
               default: cond[gi] = 1'b0;
            endcase
         end
      end
   endgenerate

   // sticky flags; set wins over a clear in the same cycle [R05]
   // flags only set on enabled pins, so disabled pins read stale [R06] [R14]
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_irq_flag_q <= `GPC_RST_WORD;
      end else begin
         pin_irq_flag_q <= (pin_irq_flag_q & ~clr_mask)
                         | (cond & pin_irq_enable_q & IMPL_PINS); // [R15]
      end
   end

   // level interrupt, one cycle behind the flag [R17]
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(pin_irq_flag_q & pin_irq_enable_q);
      end
   end

   // event pulses, gated per pin [R10]
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_event_q <= `GPC_RST_WORD;
      end else begin
         pin_event_q <= cond & event_forward_on_q & IMPL_PINS;
      end
   end

   // outputs straight from flops
   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign drive_strength_bit_low = drive_low_q;
   assign drive_strength_bit_high = drive_high_q;
   assign slew_control_on = slew_q;
   assign schmitt_on = schmitt_q;
   assign pin_event = pin_event_q;
   assign irq = irq_q;

endmodule

// >>> testbench/gpc_pin_model.sv
/*
 Board-side pin drivers for the port.
 Assumes the bench sets wanted levels; pins follow off the clock grid.
*/
`timescale 1ns/100ps
module gpc_pin_model (
   input wire logic [31:0] level,
   output logic [31:0] pin_in
);
   // skewed from pclk so the synchroniser sees truly async edges
   assign #7 pin_in = level;
endmodule

// >>> testbench/gpc_top_bench.sv
/*
 Self-checking bench for the pin interrupt and pad configuration block.
 Assumes gpc_top, the checker bind and the pin model are compiled first.
*/
`timescale 1ns/100ps
`include "gpc_consts.svh"
module gpc_top_bench;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [8:0] paddr = 9'h0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] level = 32'h0;
   wire [31:0] pin_in, prdata, drv_lo, drv_hi, slew, schm, pin_event;
   wire pready, pslverr, irq;
   int errors = 0;
   int comparisons = 0;
   int ev2 = 0;
   int ev3 = 0;
   gpc_pin_model gpc_pin_model_inst (.level(level), .pin_in(pin_in));
   gpc_top #(.IMPL_PINS(32'h7fffffff), .MOD_VERSION(12'h3a5), .MOD_VARIANT(4'h6)) gpc_top_inst (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .pin_in(pin_in), .drive_strength_bit_low(drv_lo), .drive_strength_bit_high(drv_hi),
      .slew_control_on(slew), .schmitt_on(schm), .pin_event(pin_event), .irq(irq));
   initial forever #20 pclk = ~pclk;
   // count event pulses mid-cycle, away from the launching edge
   always @(negedge pclk) begin
      if (pin_event[2] === 1'b1) ev2++;
      if (pin_event[3] === 1'b1) ev3++;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // one apb transfer; held until pready, then a spare idle edge
   // answer taken at the rising edge that sees pready; only the watchdog ends a hang
   task automatic apb(input logic w, input logic [8:0] a, input logic [31:0] d,
      output logic [31:0] r, output logic e);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic wr(input logic [8:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask
   task automatic rd(input logic [8:0] a, input logic [31:0] x, input logic xe);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h0, r, e);
      chk(r, x);
      chk({31'h0, e}, {31'h0, xe});
   endtask
   // pin moves, then enough edges for sync and detection
   task automatic pin(input int b, input logic v);
      level[b] <= v;
      repeat (12) @(posedge pclk);
   endtask
   task automatic pulse(input int b, input int w);
      level[b] <= 1'b1;
      repeat (w) @(posedge pclk);
      level[b] <= 1'b0;
      repeat (14) @(posedge pclk);
   endtask
   task automatic irq_is(input logic v);
      @(negedge pclk);
      chk({31'h0, irq}, {31'h0, v});
      @(posedge pclk);
   endtask
   task automatic t_regs;
      rd(`GPC_OFF_GLITCH, 32'h0, 1'b0);
      rd(`GPC_OFF_IMPL, 32'h7fffffff, 1'b0);
      rd(`GPC_OFF_VERSION, 32'h000603a5, 1'b0);
      wr(`GPC_OFF_GLITCH, 32'hfffff0f0);
      rd(`GPC_OFF_GLITCH, 32'h7ffff0f0, 1'b0);
      wr(`GPC_OFF_GLITCH + 9'h4, 32'h0000000f);
      wr(`GPC_OFF_GLITCH + 9'h8, 32'hfff000f0);
      wr(`GPC_OFF_GLITCH + 9'hc, 32'h0000ff00);
      rd(`GPC_OFF_GLITCH + 9'h4, 32'h000f0f0f, 1'b0);
      wr(`GPC_OFF_GLITCH, 32'h0);
      wr(`GPC_OFF_DRIVE_LOW, 32'h0000ffff);
      wr(`GPC_OFF_DRIVE_HIGH, 32'h00ff00ff);
      wr(`GPC_OFF_SLEW, 32'h0f0f0f0f);
      wr(`GPC_OFF_SCHMITT, 32'h33333333);
      @(negedge pclk);
      chk(drv_lo, 32'h0000ffff);
      chk(drv_hi, 32'h00ff00ff);
      chk(slew, 32'h0f0f0f0f);
      chk(schm, 32'h33333333);
      @(posedge pclk);
      wr(`GPC_OFF_IMPL, 32'h0);
      rd(`GPC_OFF_IMPL, 32'h7fffffff, 1'b0);
      rd(9'h1e0, 32'h0, 1'b1);
      $display("t_regs done");
   endtask
   task automatic t_event;
      wr(`GPC_OFF_EVENT, 32'h4);
      pin(2, 1'b1);
      pin(3, 1'b1);
      pin(2, 1'b0);
      pin(3, 1'b0);
      chk(32'(ev2), 32'h2);
      chk(32'(ev3), 32'h0);
      $display("t_event done");
   endtask
   task automatic t_modes;
      logic [1:0] m;
      wr(`GPC_OFF_IRQ_EN, 32'h1);
      for (int i = 0; i < 4; i++) begin
         m = i[1:0];
         wr(`GPC_OFF_TRIG_LOW, {31'h0, m[0]});
         wr(`GPC_OFF_TRIG_HIGH, {31'h0, m[1]});
         wr(`GPC_OFF_FLAG_CLR, 32'hffffffff);
         pin(0, 1'b1);
         rd(`GPC_OFF_FLAG_RD, {31'h0, m == 2'h0 || m == 2'h1}, 1'b0);
         irq_is(m == 2'h0 || m == 2'h1);
         wr(`GPC_OFF_FLAG_CLR, 32'h1);
         irq_is(1'b0);
         pin(0, 1'b0);
         rd(`GPC_OFF_FLAG_RD, {31'h0, m == 2'h0 || m == 2'h2}, 1'b0);
      end
      wr(`GPC_OFF_TRIG_HIGH, 32'h0);
      pin(0, 1'b1);
      wr(`GPC_OFF_FLAG_CLR, 32'h0);
      rd(`GPC_OFF_FLAG_RD, 32'h1, 1'b0);
      wr(`GPC_OFF_IRQ_EN + 9'h8, 32'h1);
      irq_is(1'b0);
      pin(1, 1'b1);
      irq_is(1'b0);
      pin(0, 1'b0);
      pin(1, 1'b0);
      $display("t_modes done");
   endtask
   task automatic t_filter;
      wr(`GPC_OFF_TRIG_LOW, 32'h0);
      wr(`GPC_OFF_GLITCH, 32'h10);
      wr(`GPC_OFF_IRQ_EN, 32'h10);
      wr(`GPC_OFF_FLAG_CLR, 32'hffffffff);
      pulse(4, 2);
      rd(`GPC_OFF_FLAG_RD, 32'h0, 1'b0);
      pulse(4, 8);
      rd(`GPC_OFF_FLAG_RD, 32'h10, 1'b0);
      wr(`GPC_OFF_IRQ_EN, 32'h0);
      wr(`GPC_OFF_GLITCH, 32'h0);
      wr(`GPC_OFF_IRQ_EN, 32'h10);
      wr(`GPC_OFF_FLAG_CLR, 32'hffffffff);
      pulse(4, 2);
      rd(`GPC_OFF_FLAG_RD, 32'h10, 1'b0);
      $display("t_filter done");
   endtask
   task automatic conclude;
      $display("counts: comparisons=%0d errors=%0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // watchdog, far beyond the few hundred cycles the tests need
   initial begin
      #400000;
      errors++;
      conclude();
   end
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_regs();
      t_event();
      t_modes();
      t_filter();
      conclude();
   end
endmodule

// >>> testbench/gpc_top_sva.sv
/*
 Checker for the pin interrupt and pad configuration block.
 Assumes the port set of gpc_top and one clock domain.
*/
`timescale 1ns/100ps
`include "gpc_consts.svh"
module gpc_top_chk (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [8:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [31:0] drive_strength_bit_low,
   input wire logic [31:0] drive_strength_bit_high,
   input wire logic [31:0] slew_control_on,
   input wire logic [31:0] schmitt_on,
   input wire logic irq
);
   // bus write in its access cycle
   logic wr;
   assign wr = psel && penable && pwrite;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   answer_next_a: assert property (psel && !penable |=> pready)
      else $error("no answer after setup");
   ready_single_a: assert property (pready |=> !pready)
      else $error("answer longer than one cycle");
   idle_quiet_a: assert property (!pready |-> prdata == 32'h0 && !pslverr)
      else $error("read data or error outside answer");
   unmapped_err_a: assert property (pready && paddr[8:4] == 5'h1e |-> pslverr)
      else $error("unmapped address not refused");
   version_word_a: assert property (pready && !pwrite && paddr == `GPC_OFF_VERSION
      |-> !pslverr && prdata[31:20] == 12'h0 && prdata[15:12] == 4'h0)
      else $error("version word malformed");
   drive_by_write_a: assert property (!$stable({drive_strength_bit_high,
      drive_strength_bit_low}) |-> $past(wr) || $past(wr, 2))
      else $error("drive strength moved without a write");
   pad_by_write_a: assert property (!$stable({slew_control_on, schmitt_on})
      |-> $past(wr) || $past(wr, 2))
      else $error("slew or schmitt moved without a write");
   // flag or enable moves at the access edge, irq one edge later, seen low one more on
   irq_drop_a: assert property ($fell(irq) |-> $past(wr, 2))
      else $error("interrupt fell without a write");
endmodule
bind gpc_top gpc_top_chk gpc_top_chk_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .drive_strength_bit_low(drive_strength_bit_low),
   .drive_strength_bit_high(drive_strength_bit_high), .slew_control_on(slew_control_on),
   .schmitt_on(schmitt_on), .irq(irq));
